// >>> tsp_timer_top.sv
//
// Summary of operation
// - Sampler takes raw count pin unscaled, else prescaler tap, at phases two and four.
// - Prescaled external input is divided first, giving a symmetrical tap to the sampler.
// - Count advances three to seven oscillator periods after a pin change.
// - One 8-bit scaler serves timer or watchdog; the other runs unscaled.
// - Low four configuration bits pick scaler owner and division ratio.
// - Any count write clears the scaler while the timer owns it.
// - Watchdog clear empties scaler and watchdog counter while watchdog owns it.
// - Scaler count is hidden from software; only clears and counting change it.
// - Scaler ownership may change at any time; a switch stops neither counter.
// - Internal source counts each instruction cycle; a write blocks two cycles.
// - Edge select bit clear counts rising pin edges, set counts falling ones.
// - Assignment bit clear gives timer the scaler, ratios 1:2 to 1:256.
// - Wrap from ff to 00 sets overflow flag, cleared by software; enable gates only the irq.
//
`timescale 1ns/1ps
`default_nettype none

module tsp_timer_top
  import tsp_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // External count pin
  input wire logic ext_count_input,
  // Block outputs
  output logic [7:0] count_value,
  output logic overflow_irq,
  output logic watchdog_reset,
  output logic [4:0] port_a_direction
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic rise_at(input logic [7:0] cur, input logic [7:0] prev,
                                   input logic [2:0] idx);
    rise_at = cur[idx] & ~prev[idx];
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [7:0] count_value_reg_q;
  logic [7:0] irq_control_reg_q;
  logic [7:0] core_cfg_q;
  logic [4:0] port_a_direction_reg_q;
  logic wdt_en_q;
  logic wdt_fired_q;
  logic [1:0] phase_q;
  logic ext_s1_q;
  logic ext_s2_q;
  logic ext_lvl_q;
  logic sample_q;
  logic sample_prev_q;
  logic [7:0] scl_prev_q;
  logic [1:0] inhibit_q;
  logic [15:0] wdt_base_q;
  logic [7:0] watchdog_timer_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic overflow_irq_q;
  logic watchdog_reset_q;

  tsp_scale_if scl_if ();

  tsp_scaler u_scaler (
    .clk(clk),
    .reset(reset),
    .sif(scl_if)
  );

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  wire logic apb_access = psel & penable;
  wire logic apb_commit = apb_access & pready_q;
  wire logic apb_wr = apb_commit & pwrite;
  wire logic sel_count = (paddr == ADDR_COUNT);
  wire logic sel_irq = (paddr == ADDR_IRQ_CTRL);
  wire logic sel_cfg = (paddr == ADDR_CORE_CFG);
  wire logic sel_dir = (paddr == ADDR_PORTA_DIR);
  wire logic sel_wdt = (paddr == ADDR_WDT_CTRL);
  wire logic sel_none = ~(sel_count | sel_irq | sel_cfg | sel_dir | sel_wdt);
  wire logic cnt_wr = apb_wr & sel_count;
  wire logic irq_wr = apb_wr & sel_irq;
  wire logic cfg_wr = apb_wr & sel_cfg;
  wire logic dir_wr = apb_wr & sel_dir;
  wire logic wdt_wr = apb_wr & sel_wdt;
  wire logic watchdog_clear_instr = wdt_wr & pwdata[WDT_CLR_BIT];

  logic [7:0] rd_byte;
  always_comb
  begin
    if (sel_count)
      rd_byte = count_value_reg_q;
    else if (sel_irq)
      rd_byte = irq_control_reg_q;
    else if (sel_cfg)
      rd_byte = core_cfg_q;
    else if (sel_dir)
      rd_byte = {3'h0, port_a_direction_reg_q};
    else if (sel_wdt)
      rd_byte = {5'h00, wdt_fired_q, wdt_en_q, 1'b0};
    else
      rd_byte = 8'h00;
  end

  // ----------------------------------------------------------------
  // Configuration fields
  // ----------------------------------------------------------------
  wire logic [2:0] scale_ratio_sel = core_cfg_q[CFG_RATIO_LSB +: 3];
  wire logic scaler_assign_sel = core_cfg_q[CFG_ASSIGN_BIT];
  wire logic count_edge_sel = core_cfg_q[CFG_EDGE_BIT];
  wire logic count_source_sel = core_cfg_q[CFG_SOURCE_BIT];
  // Ownership follows the live bit, so it may flip mid-run
  wire logic timer_owns = ~scaler_assign_sel;

  // ----------------------------------------------------------------
  // Phase clocks and pin synchroniser
  // ----------------------------------------------------------------
  wire logic instr_tick = (phase_q == PH_FOURTH);
  wire logic sample_phase = (phase_q == PH_SECOND) | (phase_q == PH_FOURTH);
  // Falling-edge select inverts the level so one rising detector serves both
  wire logic ext_lvl = ext_s2_q ^ count_edge_sel;
  wire logic ext_rise = ext_lvl & ~ext_lvl_q;

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      phase_q <= 2'h0;
      ext_s1_q <= 1'b0;
      ext_s2_q <= 1'b0;
      // Start at the idle pin level seen through the reset edge select: no false edge
      ext_lvl_q <= RST_CORE_CFG[CFG_EDGE_BIT];
    end
    else
    begin
      phase_q <= phase_q + 2'h1;
      ext_s1_q <= ext_count_input;
      ext_s2_q <= ext_s1_q;
      ext_lvl_q <= ext_lvl;
    end
  end

  // ----------------------------------------------------------------
  // Shared scaler steering
  // ----------------------------------------------------------------
  wire logic wdt_base_tick = (wdt_base_q == 16'(WDT_TICK_CYCLES - 1));
  wire logic timer_src_tick = count_source_sel ? ext_rise : instr_tick;
  assign scl_if.tick = timer_owns ? timer_src_tick : wdt_base_tick;
  assign scl_if.clear = timer_owns ? cnt_wr : watchdog_clear_instr;

  // Tap n toggles every 2^n input events, one full period is 2^(n+1)
  wire logic timer_div_rise = rise_at(scl_if.count, scl_prev_q, scale_ratio_sel);
  wire logic [2:0] wdt_tap = scale_ratio_sel - 3'h1;
  wire logic wdt_div_rise = rise_at(scl_if.count, scl_prev_q, wdt_tap);

  // ----------------------------------------------------------------
  // Sampler and increment
  // ----------------------------------------------------------------
  // Timing budget: two sync flops, one or two more edges to the sample phase,
  // then one to the counter, well inside seven oscillator periods.
  wire logic sample_src = timer_owns ? scl_if.count[scale_ratio_sel] : ext_lvl;
  wire logic sample_rise = sample_q & ~sample_prev_q;
  wire logic int_req = timer_owns ? timer_div_rise : instr_tick;
  wire logic inc_req = count_source_sel ? sample_rise : int_req;
  wire logic inc = inc_req & (inhibit_q == 2'h0) & ~cnt_wr;
  wire logic ovf_set = inc & (count_value_reg_q == 8'hff);

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      // Same idle level as the pin path, so the first sample is not a rise
      sample_q <= RST_CORE_CFG[CFG_EDGE_BIT];
      sample_prev_q <= RST_CORE_CFG[CFG_EDGE_BIT];
      scl_prev_q <= 8'h00;
    end
    else
    begin
      if (sample_phase)
        sample_q <= sample_src;
      sample_prev_q <= sample_q;
      scl_prev_q <= scl_if.count;
    end
  end

  // ----------------------------------------------------------------
  // Count and flag registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (reset)
      inhibit_q <= 2'h0;
    else if (cnt_wr)
      inhibit_q <= INHIBIT_CYCLES;
    else if (instr_tick && inhibit_q != 2'h0)
      inhibit_q <= inhibit_q - 2'h1;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      count_value_reg_q <= RST_COUNT;
    else if (cnt_wr)
      count_value_reg_q <= pwdata[7:0];
    else if (inc)
      count_value_reg_q <= count_value_reg_q + 8'h01;
  end

  // A wrap in the same cycle as a software clear keeps the flag set
  always_ff @(posedge clk)
  begin
    if (reset)
      irq_control_reg_q <= RST_IRQ_CTRL;
    else
    begin
      if (irq_wr)
        irq_control_reg_q <= pwdata[7:0];
      if (ovf_set)
        irq_control_reg_q[IRQ_FLAG_BIT] <= 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      core_cfg_q <= RST_CORE_CFG;
      port_a_direction_reg_q <= RST_PORTA_DIR;
      wdt_en_q <= RST_WDT_EN;
    end
    else
    begin
      if (cfg_wr)
        core_cfg_q <= pwdata[7:0];
      if (dir_wr)
        port_a_direction_reg_q <= pwdata[4:0];
      if (wdt_wr)
        wdt_en_q <= pwdata[WDT_EN_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Watchdog
  // ----------------------------------------------------------------
  // Without the scaler the watchdog steps on every base tick; ratio code 0
  // also means no division when it does own the scaler.
  wire logic wdt_scaled = (scale_ratio_sel == 3'h0) ? wdt_base_tick : wdt_div_rise;
  wire logic wdt_step = timer_owns ? wdt_base_tick : wdt_scaled;
  wire logic wdt_expire = wdt_step & (watchdog_timer_q == WDT_LIMIT);

  always_ff @(posedge clk)
  begin
    if (reset || wdt_base_tick)
      wdt_base_q <= 16'h0000;
    else
      wdt_base_q <= wdt_base_q + 16'h0001;
  end

  always_ff @(posedge clk)
  begin
    if (reset || watchdog_clear_instr || !wdt_en_q)
      watchdog_timer_q <= 8'h00;
    else if (wdt_step)
      watchdog_timer_q <= watchdog_timer_q + 8'h01;
  end

  // Fired flag: expiry wins over the clear written with the same access
  always_ff @(posedge clk)
  begin
    if (reset)
      wdt_fired_q <= 1'b0;
    else if (wdt_expire && wdt_en_q)
      wdt_fired_q <= 1'b1;
    else if (wdt_wr && pwdata[WDT_FIRED_BIT])
      wdt_fired_q <= 1'b0;
  end

  // ----------------------------------------------------------------
  // APB answer and outputs
  // ----------------------------------------------------------------
  // One wait state: pready rises in the second access cycle
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end
    else
    begin
      pready_q <= apb_access & ~pready_q;
      pslverr_q <= apb_access & ~pready_q & sel_none;
      prdata_q <= (apb_access && !pready_q && !pwrite) ? {24'h000000, rd_byte} : 32'h0000_0000;
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      overflow_irq_q <= 1'b0;
      watchdog_reset_q <= 1'b0;
    end
    else
    begin
      overflow_irq_q <= irq_control_reg_q[IRQ_FLAG_BIT] & irq_control_reg_q[IRQ_EN_BIT];
      watchdog_reset_q <= wdt_expire & wdt_en_q;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign count_value = count_value_reg_q;
  assign overflow_irq = overflow_irq_q;
  assign watchdog_reset = watchdog_reset_q;
  assign port_a_direction = port_a_direction_reg_q;

endmodule

`default_nettype wire

// >>> tsp_pkg.sv
package tsp_pkg;

  // ----------------------------------------------------------------
  // Register map (indices as printed, byte address is four times)
  // ----------------------------------------------------------------
  localparam logic [11:0] IDX_COUNT = 12'h001;
  localparam logic [11:0] IDX_IRQ_CTRL = 12'h00b;
  localparam logic [11:0] IDX_CORE_CFG = 12'h081;
  localparam logic [11:0] IDX_PORTA_DIR = 12'h085;
  localparam logic [11:0] IDX_WDT_CTRL = 12'h0c0;
  localparam logic [11:0] ADDR_COUNT = IDX_COUNT << 2;
  localparam logic [11:0] ADDR_IRQ_CTRL = IDX_IRQ_CTRL << 2;
  localparam logic [11:0] ADDR_CORE_CFG = IDX_CORE_CFG << 2;
  localparam logic [11:0] ADDR_PORTA_DIR = IDX_PORTA_DIR << 2;
  localparam logic [11:0] ADDR_WDT_CTRL = IDX_WDT_CTRL << 2;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_COUNT = 8'h00;
  localparam logic [7:0] RST_IRQ_CTRL = 8'h00;
  localparam logic [7:0] RST_CORE_CFG = 8'hff;
  localparam logic [4:0] RST_PORTA_DIR = 5'h1f;
  localparam logic RST_WDT_EN = 1'b1;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CFG_RATIO_LSB = 0;
  localparam int CFG_ASSIGN_BIT = 3;
  localparam int CFG_EDGE_BIT = 4;
  localparam int CFG_SOURCE_BIT = 5;
  localparam int IRQ_FLAG_BIT = 2;
  localparam int IRQ_EN_BIT = 5;
  localparam int WDT_CLR_BIT = 0;
  localparam int WDT_EN_BIT = 1;
  localparam int WDT_FIRED_BIT = 2;

  // ----------------------------------------------------------------
  // Phase clocks and timing
  // ----------------------------------------------------------------
  localparam logic [1:0] PH_SECOND = 2'h1;
  localparam logic [1:0] PH_FOURTH = 2'h3;
  localparam logic [1:0] INHIBIT_CYCLES = 2'h2;
  localparam int CLK_PERIOD_PS = 5000;
  localparam int WDT_TICK_NS = 1000;
  localparam int WDT_TICK_CYCLES = (WDT_TICK_NS * 1000) / CLK_PERIOD_PS;
  localparam logic [7:0] WDT_LIMIT = 8'hff;

endpackage

// >>> tsp_scale_if.sv
`timescale 1ns/1ps
`default_nettype none

interface tsp_scale_if;
  logic tick;
  logic clear;
  logic [7:0] count;

  modport owner (output tick, output clear, input count);
  modport scaler (input tick, input clear, output count);
endinterface

`default_nettype wire

// >>> tsp_scaler.sv
`timescale 1ns/1ps
`default_nettype none

module tsp_scaler
  import tsp_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Owner side
  tsp_scale_if.scaler sif
);

  logic [7:0] count_q;
  logic [7:0] count_d;

  // ----------------------------------------------------------------
  // Shared counter
  // ----------------------------------------------------------------
  // Each bit toggles at half the rate of the one below, so every tap is
  // a symmetrical square wave, as the ripple chain would give.
  assign count_d = sif.clear ? 8'h00 : (sif.tick ? count_q + 8'h01 : count_q);
  assign sif.count = count_q;

  always_ff @(posedge clk)
  begin
    if (reset)
      count_q <= 8'h00;
    else
      count_q <= count_d;
  end

endmodule

`default_nettype wire

// >>> tsp_timer_checker.sv
`timescale 1ns/1ps
`default_nettype none

module tsp_timer_checker
  import tsp_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Register bus
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Pin and outputs
  input wire logic ext_count_input,
  input wire logic [7:0] count_value,
  input wire logic overflow_irq,
  input wire logic watchdog_reset
);
  // --------
  // Shadow state
  // --------
  logic [7:0] cfg_q;
  logic [7:0] val_q;
  logic [2:0] sh_q;
  logic en_q;
  wire wr_ok = psel && penable && pready && pwrite;
  wire cnt_wr = wr_ok && paddr == ADDR_COUNT;
  wire mapped = paddr inside {ADDR_COUNT, ADDR_IRQ_CTRL, ADDR_CORE_CFG, ADDR_PORTA_DIR,
    ADDR_WDT_CTRL};
  // Count changes right after a write are loads, not steps
  wire recent = cnt_wr || |sh_q;

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      cfg_q <= RST_CORE_CFG;
      en_q <= 1'b0;
      sh_q <= 3'h0;
    end
    else
    begin
      sh_q <= {sh_q[1:0], cnt_wr};
      if (wr_ok && paddr == ADDR_CORE_CFG)
        cfg_q <= pwdata[7:0];
      if (wr_ok && paddr == ADDR_IRQ_CTRL)
        en_q <= pwdata[IRQ_EN_BIT];
      if (cnt_wr)
        val_q <= pwdata[7:0];
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  property p_rdy;
    psel && penable && !pready |=> pready;
  endproperty
  a_rdy: assert property (p_rdy) else $error("pready not in second access cycle");
  property p_err;
    psel && penable && pready |-> pslverr == !mapped;
  endproperty
  a_err: assert property (p_err) else $error("pslverr wrong for address");
  property p_idle;
    !pready |-> prdata == 32'h0 && !pslverr;
  endproperty
  a_idle: assert property (p_idle) else $error("read data outside answer");
  property p_wr;
    cnt_wr |-> ##[1:2] count_value == val_q ##1 (count_value == val_q) [*3];
  endproperty
  a_wr: assert property (p_wr) else $error("count write not held");
  property p_step;
    $changed(count_value) && !recent |-> count_value == $past(count_value) + 8'h1;
  endproperty
  a_step: assert property (p_step) else $error("count step not one");
  property p_irq;
    overflow_irq |-> $past(en_q);
  endproperty
  a_irq: assert property (p_irq) else $error("overflow irq while masked");
  property p_pin;
    cfg_q[5] && cfg_q[3] && !recent
      && (cfg_q[4] ? $fell(ext_count_input) : $rose(ext_count_input))
      |-> ##[3:7] $changed(count_value);
  endproperty
  a_pin: assert property (p_pin) else $error("pin edge not counted in time");
  property p_wdr;
    watchdog_reset |=> !watchdog_reset;
  endproperty
  a_wdr: assert property (p_wdr) else $error("watchdog reset too long");

  c_ovf: cover property (overflow_irq);
  c_wdr: cover property (watchdog_reset);
  c_err: cover property (pslverr);
endmodule

bind tsp_timer_top tsp_timer_checker u_chk (.clk(clk), .reset(reset), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .ext_count_input(ext_count_input),
  .count_value(count_value), .overflow_irq(overflow_irq), .watchdog_reset(watchdog_reset));

`default_nettype wire

// >>> tsp_pin_src.sv
`timescale 1ns/1ps
`default_nettype none

module tsp_pin_src
(
  // Clock and control
  input wire logic clk,
  input wire logic go,
  input wire logic [7:0] flips,
  // Pin
  output logic pin,
  output logic busy
);
  // Pin holds its level between runs, so a run may end high
  logic [7:0] left_q = 8'h0;
  logic [1:0] ph_q = 2'h0;
  logic pin_q = 1'b0;
  assign busy = left_q != 8'h0;
  assign pin = pin_q;

  always_ff @(posedge clk)
  begin
    if (go && !busy)
    begin
      left_q <= flips;
      ph_q <= 2'h0;
    end
    else if (busy)
    begin
      ph_q <= ph_q + 2'h1;
      if (ph_q == 2'h3)
      begin
        pin_q <= !pin_q;
        left_q <= left_q - 8'h1;
      end
    end
  end
endmodule

`default_nettype wire

// >>> tsp_tb.sv
`timescale 1ns/1ps
`default_nettype none

module testbench
  import tsp_pkg::*;
;
  typedef struct {logic [11:0] a; logic [7:0] d; logic [7:0] x; logic e;} tsp_row_t;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic pready, pslverr, er, pin, busy, ovf, wdr;
  logic go = 1'b0;
  logic [7:0] flips = 8'h0;
  logic [7:0] cnt;
  logic [4:0] pad;
  int err_total = 0;
  int compares = 0;
  int n;
  tsp_row_t rows [5] = '{'{ADDR_IRQ_CTRL, 8'h5b, 8'h5b, 1'b0},
    '{ADDR_PORTA_DIR, 8'hff, 8'h1f, 1'b0}, '{ADDR_CORE_CFG, 8'hf8, 8'hf8, 1'b0},
    '{ADDR_COUNT, 8'h7e, 8'h7e, 1'b0}, '{12'h010, 8'h55, 8'h00, 1'b1}};
  tsp_row_t rst [4] = '{'{ADDR_COUNT, 8'h0, RST_COUNT, 1'b0},
    '{ADDR_IRQ_CTRL, 8'h0, RST_IRQ_CTRL, 1'b0}, '{ADDR_CORE_CFG, 8'h0, RST_CORE_CFG, 1'b0},
    '{ADDR_PORTA_DIR, 8'h0, 8'h1f, 1'b0}};
  logic [7:0] pcfg [4] = '{8'h28, 8'h38, 8'h21, 8'h30};
  logic [7:0] pfl [4] = '{8'd31, 8'd31, 8'd63, 8'd31};
  logic [7:0] pexp [4] = '{8'd16, 8'd16, 8'd8, 8'd8};

  tsp_timer_top dut (.clk(clk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ext_count_input(pin), .count_value(cnt), .overflow_irq(ovf),
    .watchdog_reset(wdr), .port_a_direction(pad));
  tsp_pin_src src (.clk(clk), .go(go), .flips(flips), .pin(pin), .busy(busy));

  initial
  begin
    forever #2.5 clk = ~clk;
  end

  // --------
  // Tasks
  // --------
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    compares++;
    if (g !== x)
    begin
      err_total++;
      $display("mismatch at %0t: got %h want %h", $time, g, x);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge clk);
    penable <= 1'b1;
    // Wait as long as the slave needs; only the bench timeout ends a hang
    do
    begin
      @(posedge clk);
    end
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Cycles until the count next moves
  task automatic gap(output int c);
    logic [7:0] v;
    v = cnt;
    c = 0;
    while (cnt === v)
    begin
      @(posedge clk);
      c++;
    end
  endtask

  task automatic set_cfg(input logic [7:0] v);
    apb(1'b1, ADDR_WDT_CTRL, 8'h01);
    apb(1'b1, ADDR_CORE_CFG, v);
  endtask

  task automatic run_pin(input logic [7:0] f);
    flips <= f;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    repeat (2) @(posedge clk);
    while (busy === 1'b1) @(posedge clk);
    repeat (12) @(posedge clk);
  endtask

  task report_and_stop;
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  initial
  begin
    repeat (100000) @(posedge clk);
    err_total++;
    report_and_stop();
  end

  // --------
  // Sequence
  // --------
  initial
  begin
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    foreach (rows[i])
    begin
      apb(1'b1, rows[i].a, rows[i].d);
      chk(er, rows[i].e);
      apb(1'b0, rows[i].a, 8'h0);
      chk({er, rd[30:0]}, {rows[i].e, 23'h0, rows[i].x});
    end
    for (int k = 0; k < 8; k++)
    begin
      set_cfg(8'(k));
      gap(n);
      gap(n);
      chk(n, 8 << k);
    end
    gap(n);
    apb(1'b1, ADDR_COUNT, 8'h00);
    repeat (4) @(posedge clk);
    gap(n);
    chk(n >= 490 && n <= 530, 1);
    apb(1'b1, ADDR_WDT_CTRL, 8'h03);
    n = 0;
    while (wdr !== 1'b1 && n < 60000)
    begin
      @(posedge clk);
      n++;
    end
    chk(n >= 255 * WDT_TICK_CYCLES && n <= 257 * WDT_TICK_CYCLES, 1);
    apb(1'b0, ADDR_WDT_CTRL, 8'h0);
    chk(rd[2], 1'b1);
    apb(1'b1, ADDR_WDT_CTRL, 8'h04);
    apb(1'b0, ADDR_WDT_CTRL, 8'h0);
    chk(rd[2:1], 2'h0);
    apb(1'b1, ADDR_WDT_CTRL, 8'h01);
    apb(1'b1, ADDR_COUNT, 8'h00);
    apb(1'b1, ADDR_CORE_CFG, 8'h2f);
    apb(1'b1, ADDR_WDT_CTRL, 8'h01);
    apb(1'b1, ADDR_CORE_CFG, 8'h08);
    apb(1'b0, ADDR_CORE_CFG, 8'h0);
    chk(rd, 32'h08);
    for (int i = 0; i < 2; i++)
    begin
      apb(1'b1, ADDR_IRQ_CTRL, (i == 0) ? 8'h20 : 8'h00);
      apb(1'b1, ADDR_COUNT, 8'hfe);
      repeat (3) @(posedge clk);
      gap(n);
      chk(n >= 5 && n <= 11, 1);
      repeat (30) @(posedge clk);
      chk(ovf, i == 0);
      apb(1'b0, ADDR_IRQ_CTRL, 8'h0);
      chk(rd, (i == 0) ? 32'h24 : 32'h04);
    end
    gap(n);
    gap(n);
    chk(n, 4);
    foreach (pcfg[i])
    begin
      set_cfg(pcfg[i]);
      apb(1'b1, ADDR_COUNT, 8'h00);
      repeat (12) @(posedge clk);
      run_pin(pfl[i]);
      chk(cnt, pexp[i]);
    end
    apb(1'b1, ADDR_PORTA_DIR, 8'h00);
    reset <= 1'b1;
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    chk({cnt, 3'h0, pad}, {RST_COUNT, 3'h0, RST_PORTA_DIR});
    foreach (rst[i])
    begin
      apb(1'b0, rst[i].a, 8'h0);
      chk(rd, {24'h0, rst[i].x});
    end
    report_and_stop();
  end
endmodule

`default_nettype wire
